// ### rtl/blrx_pkg.sv
package blrx_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_INTERRUPT_RETURN_OP    = 8'hBF;
  localparam logic [7:0] OP_JP_RR   = 8'h30;
  localparam logic [3:0] NIB_JP_CC  = 4'hD;
  localparam logic [3:0] NIB_JR     = 4'hB;
  localparam logic [3:0] NIB_LD_IM  = 4'hC;
  localparam logic [3:0] NIB_LD_RR  = 4'h8;
  localparam logic [3:0] NIB_LD_WR  = 4'h9;
  localparam logic [7:0] OP_LD_C7   = 8'hC7;
  localparam logic [7:0] OP_LD_D7   = 8'hD7;
  localparam logic [7:0] OP_LD_E4   = 8'hE4;
  localparam logic [7:0] OP_LD_E5   = 8'hE5;
  localparam logic [7:0] OP_LD_E6   = 8'hE6;
  localparam logic [7:0] OP_LD_D6   = 8'hD6;
  localparam logic [7:0] OP_LD_F5   = 8'hF5;
  localparam logic [7:0] OP_LD_87   = 8'h87;
  localparam logic [7:0] OP_LD_97   = 8'h97;

  // ----------------------------------------------------------------
  // cycle counts and lengths
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_INTERRUPT_RETURN_OP_N = 4'hA;
  localparam logic [3:0] CYC_INTERRUPT_RETURN_OP_X = 4'hC;
  localparam logic [3:0] CYC_INTERRUPT_RETURN_OP_F = 4'h6;
  localparam logic [3:0] CYC_JP     = 4'h8;
  localparam logic [3:0] CYC_JR     = 4'h6;
  localparam logic [3:0] CYC_LD2    = 4'h4;
  localparam logic [3:0] CYC_LD3    = 4'h6;
  localparam logic [3:0] CYC_ILL    = 4'h1;
  localparam logic [1:0] LEN1       = 2'h1;
  localparam logic [1:0] LEN2       = 2'h2;
  localparam logic [1:0] LEN3       = 2'h3;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAGS_IDX   = 8'hD5;
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_INSTR   = 12'h004;
  localparam logic [11:0] OFF_PC      = 12'h008;
  localparam logic [11:0] OFF_SP      = 12'h00C;
  localparam logic [11:0] OFF_IP      = 12'h010;
  localparam logic [11:0] OFF_SHADOW  = 12'h014;
  localparam logic [11:0] OFF_SYM     = 12'h018;
  localparam logic [11:0] OFF_STATUS  = 12'h01C;
  localparam logic [11:0] OFF_RF_LO   = 12'h040;
  localparam logic [11:0] OFF_RF_HI   = 12'h07C;
  localparam logic [11:0] OFF_FLAGS   = {2'h0, FLAGS_IDX, 2'h0};

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_FIRQ  = 1;
  localparam int unsigned CTRL_XSTK  = 2;
  localparam int unsigned FIS_BIT    = 1;
  localparam int unsigned GIE_BIT    = 0;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [15:0] IP_RST     = 16'h0000;
  localparam logic [7:0]  SP_RST     = 8'h00;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  SYM_RST    = 8'h00;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;

  typedef enum logic [4:0] {
    KD_ILL, KD_INTERRUPT_RETURN_OP_N, KD_INTERRUPT_RETURN_OP_F, KD_JP_CC, KD_JP_RR, KD_JR,
    KD_LD_IM, KD_LD_RR, KD_LD_WR, KD_LD_C7, KD_LD_D7, KD_LD_E4,
    KD_LD_E5, KD_LD_E6, KD_LD_D6, KD_LD_F5, KD_LD_87, KD_LD_97
  } blrx_kind_e;

endpackage

// ### rtl/blrx_decode.sv
`timescale 1ns/1ns
`default_nettype none
module blrx_decode (
  // opcode and mode
  input  wire logic [7:0]         i_op,
  input  wire logic               i_fis,
  input  wire logic               i_xstk,
  // decoded
  output var  blrx_pkg::blrx_kind_e o_kind,
  output var  logic [1:0]         o_len,
  output var  logic [3:0]         o_cyc
);
  import blrx_pkg::*;

  always_comb begin
    o_kind = KD_ILL;
    o_len  = LEN1;
    o_cyc  = CYC_ILL;
    case (i_op)
      OP_INTERRUPT_RETURN_OP: begin
        o_kind = i_fis ? KD_INTERRUPT_RETURN_OP_F : KD_INTERRUPT_RETURN_OP_N;
        o_cyc  = i_fis ? CYC_INTERRUPT_RETURN_OP_F : (i_xstk ? CYC_INTERRUPT_RETURN_OP_X : CYC_INTERRUPT_RETURN_OP_N);
      end
      OP_JP_RR: begin
        o_kind = KD_JP_RR;
        o_len  = LEN2;
        o_cyc  = CYC_JP;
      end
      OP_LD_C7, OP_LD_D7: begin
        o_kind = (i_op == OP_LD_C7) ? KD_LD_C7 : KD_LD_D7;
        o_len  = LEN2;
        o_cyc  = CYC_LD2;
      end
      OP_LD_E4, OP_LD_E5, OP_LD_E6, OP_LD_D6, OP_LD_F5, OP_LD_87, OP_LD_97: begin
        o_len = LEN3;
        o_cyc = CYC_LD3;
        case (i_op)
          OP_LD_E4: o_kind = KD_LD_E4;
          OP_LD_E5: o_kind = KD_LD_E5;
          OP_LD_E6: o_kind = KD_LD_E6;
          OP_LD_D6: o_kind = KD_LD_D6;
          OP_LD_F5: o_kind = KD_LD_F5;
          OP_LD_87: o_kind = KD_LD_87;
          default:  o_kind = KD_LD_97;
        endcase
      end
      default: begin
        case (i_op[3:0])
          NIB_JP_CC: begin
            o_kind = KD_JP_CC;
            o_len  = LEN3;
            o_cyc  = CYC_JP;
          end
          NIB_JR: begin
            o_kind = KD_JR;
            o_len  = LEN2;
            o_cyc  = CYC_JR;
          end
          NIB_LD_IM, NIB_LD_RR, NIB_LD_WR: begin
            o_kind = (i_op[3:0] == NIB_LD_IM) ? KD_LD_IM :
                     (i_op[3:0] == NIB_LD_RR) ? KD_LD_RR : KD_LD_WR;
            o_len  = LEN2;
            o_cyc  = CYC_LD2;
          end
          default: o_kind = KD_ILL;
        endcase
      end
    endcase
  end
endmodule // blrx_decode
`default_nettype wire

// ### rtl/blrx_exec.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module blrx_exec (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // axi4-lite write
  input  wire logic        i_awvalid,
  input  wire logic [11:0] i_awaddr,
  output var  logic        o_awready,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output var  logic        o_wready,
  output var  logic        o_bvalid,
  output var  logic [1:0]  o_bresp,
  input  wire logic        i_bready,
  // axi4-lite read
  input  wire logic        i_arvalid,
  input  wire logic [11:0] i_araddr,
  output var  logic        o_arready,
  output var  logic        o_rvalid,
  output var  logic [31:0] o_rdata,
  output var  logic [1:0]  o_rresp,
  input  wire logic        i_rready,
  // status
  output var  logic        o_busy
);
  import blrx_pkg::*;

  typedef struct packed {
    logic             awrdy;
    logic             wrdy;
    logic             bval;
    logic [1:0]       bresp;
    logic             arrdy;
    logic             rval;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             aw_hold;
    logic [11:0]      awaddr;
    logic             w_hold;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic [15:0]      pc;
    logic [7:0]       sp;
    logic [7:0]       flags;
    logic [7:0]       shadow;
    logic [15:0]      ip;
    logic [7:0]       system_mode_reg;
    logic             xstk;
    logic [23:0]      instr;
    logic             busy;
    logic [3:0]       cnt;
    logic [1:0]       len;
    blrx_kind_e       kind;
    logic             ill;
    logic             taken;
    logic [3:0]       last_cyc;
    logic [15:0][7:0] rf;
  } blrx_state_s;

  blrx_state_s q;
  blrx_state_s d;

  blrx_kind_e  dec_kind;
  logic [1:0]  dec_len;
  logic [3:0]  dec_cyc;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic        wr_go;
  logic        start_go;
  logic        firq_go;
  logic        done;
  logic        cc_true;
  logic [32:0] rd_w;
  logic [32:0] rd_r;
  logic [31:0] wv32;
  logic [7:0]  ld_a;
  logic [7:0]  ld_v;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // {hit, data}; unmapped or misaligned gives hit low
  function automatic logic [32:0] rd_reg(input logic [11:0] a, input blrx_state_s s);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    if (a >= OFF_RF_LO && a <= OFF_RF_HI && a[1:0] == 2'h0) begin
      r[7:0] = s.rf[a[5:2]];
    end else begin
      case (a)
        OFF_CTRL:   r[CTRL_XSTK] = s.xstk;
        OFF_INSTR:  r[23:0] = s.instr;
        OFF_PC:     r[15:0] = s.pc;
        OFF_SP:     r[7:0] = s.sp;
        OFF_IP:     r[15:0] = s.ip;
        OFF_SHADOW: r[7:0] = s.shadow;
        OFF_SYM:    r[7:0] = s.system_mode_reg;
        OFF_FLAGS:  r[7:0] = s.flags;
        OFF_STATUS: r[15:0] = {4'h0, s.last_cyc, 5'h00, s.taken, s.ill, s.busy};
        default:    r[32] = 1'b0;
      endcase
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] st);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[8*i +: 8] = n[8*i +: 8];
      end
    end
    return m;
  endfunction

  // condition table: low three bits pick a test, top bit inverts it
  function automatic logic cond(input logic [3:0] cc, input logic [7:0] f);
    logic t;
    case (cc[2:0])
      3'h0:    t = 1'b0;
      3'h1:    t = f[5] ^ f[4];
      3'h2:    t = f[6] | (f[5] ^ f[4]);
      3'h3:    t = f[7] | f[6];
      3'h4:    t = f[4];
      3'h5:    t = f[5];
      3'h6:    t = f[6];
      default: t = f[7];
    endcase
    return t ^ cc[3];
  endfunction

  blrx_decode u_dec (
    .i_op   (q.instr[7:0]),
    .i_fis  (q.flags[FIS_BIT]),
    .i_xstk (q.xstk),
    .o_kind (dec_kind),
    .o_len  (dec_len),
    .o_cyc  (dec_cyc)
  );

  assign b0       = q.instr[7:0];
  assign b1       = q.instr[15:8];
  assign b2       = q.instr[23:16];
  assign wr_go    = q.aw_hold && q.w_hold && !q.bval;
  assign wv32     = merge(rd_w[31:0], q.wdata, q.wstrb);
  assign rd_w     = rd_reg(q.awaddr, q);
  assign rd_r     = rd_reg(i_araddr, q);
  assign firq_go  = wr_go && !q.busy && q.awaddr == OFF_CTRL && q.wstrb[0] && q.wdata[CTRL_FIRQ];
  assign start_go = wr_go && !q.busy && q.awaddr == OFF_CTRL && q.wstrb[0] && q.wdata[CTRL_START]
                    && !q.wdata[CTRL_FIRQ];
  assign done     = q.busy && q.cnt == 4'h1;
  assign cc_true  = cond(b0[7:4], q.flags);

  // ----------------------------------------------------------------
  // load operand paths
  // ----------------------------------------------------------------
  always_comb begin
    ld_a = 8'h00;
    ld_v = 8'h00;
    case (q.kind)
      KD_LD_IM: begin ld_a = {4'h0, b0[7:4]}; ld_v = b1; end
      KD_LD_RR: begin ld_a = {4'h0, b0[7:4]}; ld_v = q.rf[b1[3:0]]; end
      KD_LD_WR: begin ld_a = b1; ld_v = q.rf[b0[7:4]]; end
      KD_LD_C7: begin ld_a = {4'h0, b1[7:4]}; ld_v = q.rf[q.rf[b1[3:0]][3:0]]; end
      KD_LD_D7: begin ld_a = q.rf[b1[7:4]]; ld_v = q.rf[b1[3:0]]; end
      KD_LD_E4: begin ld_a = b2; ld_v = q.rf[b1[3:0]]; end
      KD_LD_E5: begin ld_a = b2; ld_v = q.rf[q.rf[b1[3:0]][3:0]]; end
      KD_LD_E6: begin ld_a = b1; ld_v = b2; end
      KD_LD_D6: begin ld_a = q.rf[b1[3:0]]; ld_v = b2; end
      KD_LD_F5: begin ld_a = q.rf[b2[3:0]]; ld_v = q.rf[b1[3:0]]; end
      KD_LD_87: begin ld_a = {4'h0, b1[7:4]}; ld_v = q.rf[4'(b2 + q.rf[b1[3:0]])]; end
      KD_LD_97: begin ld_a = b2 + q.rf[b1[3:0]]; ld_v = q.rf[b1[7:4]]; end
      default:  begin ld_a = 8'h00; ld_v = 8'h00; end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // bus: each channel held until taken, one write and one read at a time
    if (q.bval && i_bready) begin
      d.bval = 1'b0;
    end
    if (q.awrdy && i_awvalid) begin
      d.aw_hold = 1'b1;
      d.awaddr  = i_awaddr;
    end
    if (q.wrdy && i_wvalid) begin
      d.w_hold = 1'b1;
      d.wdata  = i_wdata;
      d.wstrb  = i_wstrb;
    end
    if (wr_go) begin
      d.aw_hold = 1'b0;
      d.w_hold  = 1'b0;
      d.bval    = 1'b1;
      d.bresp   = rd_w[32] ? RESP_OK : RESP_ERR;
      case (q.awaddr)
        OFF_CTRL:   d.xstk = wv32[CTRL_XSTK];
        OFF_INSTR:  d.instr = wv32[23:0];
        OFF_PC:     d.pc = wv32[15:0];
        OFF_SP:     d.sp = wv32[7:0];
        OFF_IP:     d.ip = wv32[15:0];
        OFF_SHADOW: d.shadow = wv32[7:0];
        OFF_SYM:    d.system_mode_reg = wv32[7:0];
        OFF_FLAGS:  d.flags = wv32[7:0];
        default: begin
          if (rd_w[32] && q.awaddr >= OFF_RF_LO && q.awaddr <= OFF_RF_HI) begin
            d.rf[q.awaddr[5:2]] = wv32[7:0];
          end
        end
      endcase
    end
    d.awrdy = !d.aw_hold && !d.bval;
    d.wrdy  = !d.w_hold && !d.bval;
    if (q.rval && i_rready) begin
      d.rval = 1'b0;
    end
    if (q.arrdy && i_arvalid) begin
      d.rval  = 1'b1;
      d.rdata = rd_r[31:0];
      d.rresp = rd_r[32] ? RESP_OK : RESP_ERR;
    end
    d.arrdy = !d.rval;

    // fast interrupt entry; wins over a start in the same write
    if (firq_go) begin
      d.pc             = q.ip;
      d.ip             = q.pc;
      d.shadow         = q.flags;
      d.flags[FIS_BIT] = 1'b1;
    end

    // start: mode picked from the fast bit at this moment
    if (start_go) begin
      d.busy     = 1'b1;
      d.cnt      = dec_cyc;
      d.kind     = dec_kind;
      d.len      = dec_len;
      d.last_cyc = dec_cyc;
      d.ill      = 1'b0;
    end

    // effects land on the last cycle so the count is visible as busy time
    if (q.busy) begin
      d.cnt = q.cnt - 4'h1;
      if (done) begin
        d.busy = 1'b0;
        case (q.kind)
          KD_INTERRUPT_RETURN_OP_N: begin
            d.flags        = q.rf[q.sp[3:0]];
            d.pc           = {q.rf[4'(q.sp + 8'h01)], q.rf[4'(q.sp + 8'h02)]};
            d.sp           = q.sp + 8'h03;
            d.system_mode_reg[GIE_BIT] = 1'b1;
          end
          KD_INTERRUPT_RETURN_OP_F: begin
            d.pc             = q.ip;
            d.ip             = q.pc;
            d.flags          = q.shadow;
            d.flags[FIS_BIT] = 1'b0;
          end
          KD_JP_CC: begin
            d.taken = cc_true;
            d.pc    = cc_true ? {b1, b2} : q.pc + 16'h0003;
          end
          KD_JP_RR: begin
            d.taken = 1'b1;
            d.pc    = {q.rf[b1[3:0]], q.rf[4'(b1 + 8'h01)]};
          end
          KD_JR: begin
            d.taken = cc_true;
            d.pc    = q.pc + 16'h0002 + (cc_true ? {{8{b1[7]}}, b1} : 16'h0000);
          end
          KD_ILL: d.ill = 1'b1;
          default: begin
            d.rf[ld_a[3:0]] = ld_v;
            d.pc            = q.pc + {14'h0000, q.len};
          end
        endcase
        // flags untouched for jumps and loads
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      q       <= '0;
      q.pc    <= PC_RST;
      q.ip    <= IP_RST;
      q.sp    <= SP_RST;
      q.flags <= FLAGS_RST;
      q.system_mode_reg   <= SYM_RST;
      q.kind  <= KD_ILL;
    end else begin
      q <= d;
    end
  end

  assign o_awready = q.awrdy;
  assign o_wready  = q.wrdy;
  assign o_bvalid  = q.bval;
  assign o_bresp   = q.bresp;
  assign o_arready = q.arrdy;
  assign o_rvalid  = q.rval;
  assign o_rdata   = q.rdata;
  assign o_rresp   = q.rresp;
  assign o_busy    = q.busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0]  stk_top;
  logic        fis_now;
  logic [15:0] jr_tgt;
  logic [15:0] pair;
  logic        jmp_or_ld;
  assign stk_top   = q.rf[q.sp[3:0]];
  assign fis_now   = q.flags[FIS_BIT];
  assign jr_tgt    = q.pc + 16'h0002 + {{8{b1[7]}}, b1};
  assign pair      = {q.rf[b1[3:0]], q.rf[4'(b1 + 8'h01)]};
  assign jmp_or_ld = q.kind != KD_INTERRUPT_RETURN_OP_N && q.kind != KD_INTERRUPT_RETURN_OP_F && q.kind != KD_ILL;

  AST_RET_POP: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (done && q.kind == KD_INTERRUPT_RETURN_OP_N) |=> (q.sp == $past(q.sp) + 8'h03) && (q.flags == $past(stk_top)))
    else $error("normal return pop wrong");
  AST_RET_GIE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (done && q.kind == KD_INTERRUPT_RETURN_OP_N) |=> q.system_mode_reg[GIE_BIT])
    else $error("normal return left interrupts off");
  AST_RET_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (start_go && b0 == OP_INTERRUPT_RETURN_OP) |=> q.kind == ($past(fis_now) ? KD_INTERRUPT_RETURN_OP_F : KD_INTERRUPT_RETURN_OP_N))
    else $error("return variant chosen wrongly");
  AST_FAST_RET: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (done && q.kind == KD_INTERRUPT_RETURN_OP_F) |=> !fis_now && q.pc == $past(q.ip) && q.ip == $past(q.pc))
    else $error("fast return swap or status wrong");
  AST_FAST_ENTRY: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    firq_go |=> fis_now && q.pc == $past(q.ip) && q.ip == $past(q.pc))
    else $error("fast entry swap wrong");
  AST_FAST_CYC: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (start_go && dec_kind == KD_INTERRUPT_RETURN_OP_F) |=> q.busy [*6] ##1 !q.busy)
    else $error("fast return not 6 cycles");
  AST_NORM_CYC: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (start_go && dec_kind == KD_INTERRUPT_RETURN_OP_N && !q.xstk) |-> ##10 q.busy ##1 !q.busy)
    else $error("normal return not 10 cycles");
  AST_JPCC_MISS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (done && q.kind == KD_JP_CC && !cc_true) |=> q.pc == $past(q.pc) + 16'h0003)
    else $error("false jump did not fall through");
  AST_JP_PAIR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (done && q.kind == KD_JP_RR) |=> q.pc == $past(pair))
    else $error("pair jump target wrong");
  AST_JR_TAKEN: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (done && q.kind == KD_JR && cc_true) |=> q.pc == $past(jr_tgt))
    else $error("relative target wrong");
  AST_FLAGS_KEEP: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (done && jmp_or_ld && !wr_go) |=> $stable(q.flags))
    else $error("jump or load changed flags");
  AST_LD_SHORT: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (start_go && dec_kind == KD_LD_IM) |=> q.busy [*4] ##1 !q.busy)
    else $error("short load not 4 cycles");

endmodule // blrx_exec
`default_nettype wire

// ### verif/blrx_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none
module blrx_exec_tb;
  import blrx_pkg::*;
  typedef struct {
    logic [23:0] ins;
    logic [15:0] pc;
    logic [3:0]  cy;
    logic [11:0] ca;
    logic [15:0] cv;
    logic [7:0]  fl;
  } blrx_row_s;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rdat, d;
  logic        awr, wrdy, bv, arr, rv, busy;
  logic [1:0]  br, rrsp, r;
  logic [15:0] pc0 = 16'h0100;
  logic [7:0]  f0 = 8'h90;
  logic        xs = 1'b0;
  int          err_count = 0;
  int          n_tests = 0;
  blrx_row_s   rows [5] = '{
    '{24'h000030, 16'h0120, 4'h8, OFF_FLAGS, 16'h0090, 8'h90},
    '{24'h00A55C, 16'h0102, 4'h4, 12'h054, 16'h00A5, 8'h90},
    '{24'h3C06E6, 16'h0103, 4'h6, 12'h058, 16'h003C, 8'h90},
    '{24'h0700E4, 16'h0103, 4'h6, 12'h05C, 16'h0001, 8'h90},
    '{24'h0000BF, 16'h1234, 4'hA, OFF_SP, 16'h000D, 8'h40}
  };

  blrx_exec uut (
    .i_clk_sys(clk), .i_nrst(nrst),
    .i_awvalid(awv), .i_awaddr(awa), .o_awready(awr),
    .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hF), .o_wready(wrdy),
    .o_bvalid(bv), .o_bresp(br), .i_bready(bry),
    .i_arvalid(arv), .i_araddr(ara), .o_arready(arr),
    .o_rvalid(rv), .o_rdata(rdat), .o_rresp(rrsp), .i_rready(rry),
    .o_busy(busy)
  );

  always #10 clk = ~clk;

  // ----
  // bus tasks and checks
  // ----
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int t;
    t = 0;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= v;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awr && awv) awv <= 1'b0;
      if (wrdy && wv) wv <= 1'b0;
    end while (!bv && t < 50);
    rs = br;
    bry <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int t;
    t = 0;
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arr && arv) arv <= 1'b0;
    end while (!rv && t < 50);
    v = rdat;
    rs = rrsp;
    rry <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(nm, e, v);
  endtask

  task automatic run(input logic [23:0] ins, input logic [15:0] pc, input logic [3:0] cy,
                     input logic [11:0] ca, input logic [15:0] cv, input logic [7:0] fl);
    logic [1:0]  rs;
    logic [31:0] v;
    int          n;
    wr(OFF_PC, {16'h0, pc0}, rs);
    wr(OFF_FLAGS, {24'h0, f0}, rs);
    wr(OFF_SP, 32'h0000000A, rs);
    wr(OFF_INSTR, {8'h0, ins}, rs);
    // stack mode must settle before the start write decodes the cycle count
    wr(OFF_CTRL, {29'h0, xs, 2'h0}, rs);
    wr(OFF_CTRL, {29'h0, xs, 2'h1}, rs);
    // the bvalid edge already showed one busy cycle
    n = 1;
    while (busy === 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    chk("busy len", {28'h0, cy}, 32'(n));
    rd(OFF_STATUS, v, rs);
    chk("cycles", {28'h0, cy}, {28'h0, v[11:8]});
    rchk(OFF_PC, {16'h0, pc}, "pc");
    rchk(ca, {16'h0, cv}, "target");
    rchk(OFF_FLAGS, {24'h0, fl}, "flags");
  endtask

  function automatic logic ccok(input logic [3:0] c, input logic [7:0] f);
    logic b;
    case (c[2:0])
      3'h0: b = 1'b0;
      3'h1: b = f[5] ^ f[4];
      3'h2: b = f[6] | (f[5] ^ f[4]);
      3'h3: b = f[7] | f[6];
      3'h4: b = f[4];
      3'h5: b = f[5];
      3'h6: b = f[6];
      default: b = f[7];
    endcase
    return b ^ c[3];
  endfunction

  // ----
  // sequence
  // ----
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(OFF_PC, 32'h0, "pc reset");
    rchk(OFF_FLAGS, 32'h0, "flags reset");
    rchk(OFF_SYM, 32'h0, "sym reset");
    rd(12'h020, d, r);
    chk("rd unmapped", {30'h0, RESP_ERR}, {30'h0, r});
    wr(12'h020, 32'h000000FF, r);
    chk("wr unmapped", {30'h0, RESP_ERR}, {30'h0, r});
    wr(OFF_RF_LO, 32'h01, r);
    wr(12'h044, 32'h20, r);
    wr(12'h068, 32'h40, r);
    wr(12'h06C, 32'h12, r);
    wr(12'h070, 32'h34, r);
    foreach (rows[i]) run(rows[i].ins, rows[i].pc, rows[i].cy, rows[i].ca, rows[i].cv, rows[i].fl);
    rchk(OFF_SYM, 32'h1, "sym after return");
    rchk(OFF_RF_LO, 32'h1, "load source");
    for (int c = 0; c < 16; c++) begin
      run({16'h0010, 4'(c), NIB_JR}, ccok(4'(c), f0) ? 16'h0112 : 16'h0102, CYC_JR, OFF_SP, 16'h000A, f0);
      run({16'h5634, 4'(c), NIB_JP_CC}, ccok(4'(c), f0) ? 16'h3456 : 16'h0103, CYC_JP, OFF_SP, 16'h000A, f0);
    end
    run(24'h00808B, 16'h0082, CYC_JR, OFF_SP, 16'h000A, f0);
    run(24'h007F8B, 16'h0181, CYC_JR, OFF_SP, 16'h000A, f0);
    // slow stack only stretches the normal return
    xs = 1'b1;
    run(24'h0000BF, 16'h1234, 4'hC, OFF_SP, 16'h000D, 8'h40);
    xs = 1'b0;
    wr(OFF_PC, 32'h0100, r);
    wr(OFF_IP, 32'h0200, r);
    wr(OFF_FLAGS, 32'h90, r);
    wr(OFF_CTRL, 32'h2, r);
    rchk(OFF_PC, 32'h0200, "entry pc");
    rchk(OFF_IP, 32'h0100, "entry ptr");
    rchk(OFF_SHADOW, 32'h90, "entry shadow");
    rchk(OFF_FLAGS, 32'h92, "entry flags");
    wr(OFF_SHADOW, 32'h16, r);
    pc0 = 16'h0200;
    f0 = 8'h92;
    // no pending clear is issued right before the fast return
    run(24'h0000BF, 16'h0100, CYC_INTERRUPT_RETURN_OP_F, OFF_IP, 16'h0200, 8'h14);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule // blrx_exec_tb
`default_nettype wire
